//--- ssm_monitor.sv
// Top of the safety stop input monitor with mute and lamp handling.
`timescale 1ns/10ps
module ssm_monitor
  import ssm_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = SIMUL_CYC,
  parameter int unsigned RESET_MIN_CYC = RST_MIN_CYC,
  parameter int unsigned RESET_MAX_CYC = RST_MAX_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire ssm_pair_t i_mutable_stop_interface,
  input wire ssm_pair_t i_general_stop_interface,
  input wire logic i_general_contact_mode,
  input wire logic i_mutable_contact_mode,
  input wire ssm_mute_pair_t i_mute_pair_one,
  input wire ssm_mute_pair_t i_mute_pair_two,
  input wire logic i_pair_two_enable,
  input wire logic i_lamp_monitor_select,
  input wire logic i_lamp_ok,
  input wire logic i_manual_reset_mode,
  input wire logic i_reset_button,
  input wire logic i_hazard_phase,
  output ssm_pair_t o_general_handshake,
  output ssm_pair_t o_mutable_handshake,
  output logic o_safety_out,
  output logic o_green,
  output logic o_aux_out,
  output logic o_mute_indicator_out,
  output logic o_muted,
  output logic o_lockout,
  output logic o_lamp_fault
);
  // Refuse at elaboration bounds that the reset check cannot serve.
  if (RESET_MIN_CYC < 1 || RESET_MAX_CYC <= RESET_MIN_CYC) begin : g_bad_rst
    $error("Reset hold bounds are not usable.");
  end
  // A contact opening can look mismatched for two handshake phases, so a
  // window that short would lock out on every honest opening.
  if (WINDOW_CYC <= 2 * HS_PHASE_CYC) begin : g_bad_window
    $error("Simultaneity window is too short for the handshake phases.");
  end

  localparam int RW = $clog2(RESET_MAX_CYC + 2);
  localparam int MW = $clog2(WINDOW_CYC + 2);
  localparam int HW = $clog2(HS_PHASE_CYC + 1);

  // Handshake test: phase counter and which channel is being pulsed low.
  logic [HW-1:0] hs_cnt_q;
  logic [1:0] hs_sel_q;
  // One-cycle contact wiring fault pulses for each interface.
  logic gen_fault_q;
  logic mut_fault_q;
  // Reset button hold counter and accepted-reset pulse.
  logic [RW-1:0] rb_cnt_q;
  logic rst_ok_q;
  // A manual reset is still owed after a lockout cleared.
  logic need_reset_q;
  // Mute pair activation timers and valid-pair flags.
  logic [MW-1:0] m1_cnt_q;
  logic [MW-1:0] m2_cnt_q;
  logic m1_ok_q;
  logic m2_ok_q;
  // Muted state, safety output register and lamp fault flag.
  logic muted_q;
  logic run_q;
  logic lamp_fault_q;

  wire gen_closed;
  wire gen_lock;
  wire mut_closed;
  wire mut_lock;
  // Channel levels with the handshake-driven lows masked in contact mode.
  ssm_pair_t gen_eff;
  ssm_pair_t mut_eff;

  // Contact faults feed the checkers so they share the lockout latch.
  ssm_simul #(.WINDOW_CYC(WINDOW_CYC)) u_general (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_chan(gen_eff),
    .i_fault(gen_fault_q),
    .o_closed(gen_closed),
    .o_lockout(gen_lock),
    .o_cycled()
  );

  ssm_simul #(.WINDOW_CYC(WINDOW_CYC)) u_mutable (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_chan(mut_eff),
    .i_fault(mut_fault_q),
    .o_closed(mut_closed),
    .o_lockout(mut_lock),
    .o_cycled()
  );

  // Handshake drive: both high, then A low alone, then B low alone.
  wire hs_a = ~hs_sel_q[0];
  wire hs_b = ~hs_sel_q[1];
  wire hs_end = hs_cnt_q == HW'(HS_PHASE_CYC - 1);

  // A channel whose handshake is held low cannot show its contact, so it
  // counts as closed for that phase. Limitation: a lone opening on that
  // channel is seen up to one phase late; the other channel still drops.
  assign gen_eff = '{
    chan_a: i_general_stop_interface.chan_a |
            (i_general_contact_mode & ~hs_a),
    chan_b: i_general_stop_interface.chan_b |
            (i_general_contact_mode & ~hs_b)};
  assign mut_eff = '{
    chan_a: i_mutable_stop_interface.chan_a |
            (i_mutable_contact_mode & ~hs_a),
    chan_b: i_mutable_stop_interface.chan_b |
            (i_mutable_contact_mode & ~hs_b)};

  // Step the handshake phase; each phase lasts a fixed number of cycles.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hs_cnt_q <= '0;
      hs_sel_q <= 2'h0;
    end else if (hs_end) begin
      hs_cnt_q <= '0;
      hs_sel_q <= (hs_sel_q == 2'h0) ? 2'h1 :
                  (hs_sel_q == 2'h1) ? 2'h2 : 2'h0;
    end else begin
      hs_cnt_q <= hs_cnt_q + HW'(1);
    end
  end

  // A closed contact must echo only its own handshake. Echo while driven
  // low means foreign supply or cross short; no echo while driven high on
  // a closed pair means high resistance or lost ground. Checks at phase end
  // only, so wiring capacitance has settled.
  wire gen_bad = hs_end &&
    ((i_general_stop_interface.chan_a && !hs_a) ||
     (i_general_stop_interface.chan_b && !hs_b) ||
     (gen_closed && hs_sel_q == 2'h0 &&
      !(i_general_stop_interface.chan_a && i_general_stop_interface.chan_b)));
  wire mut_bad = hs_end &&
    ((i_mutable_stop_interface.chan_a && !hs_a) ||
     (i_mutable_stop_interface.chan_b && !hs_b) ||
     (mut_closed && hs_sel_q == 2'h0 &&
      !(i_mutable_stop_interface.chan_a && i_mutable_stop_interface.chan_b)));

  // Fault flags pulse into the lockout latch; contact mode only.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      gen_fault_q <= 1'b0;
      mut_fault_q <= 1'b0;
    end else begin
      gen_fault_q <= i_general_contact_mode && gen_bad;
      mut_fault_q <= i_mutable_contact_mode && mut_bad;
    end
  end

  // Reset button: accept release after a hold inside the legal band.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rb_cnt_q <= '0;
      rst_ok_q <= 1'b0;
    end else begin
      rst_ok_q <= !i_reset_button && rb_cnt_q >= RW'(RESET_MIN_CYC) &&
                  rb_cnt_q <= RW'(RESET_MAX_CYC);
      if (!i_reset_button) begin
        rb_cnt_q <= '0;
      end else if (rb_cnt_q <= RW'(RESET_MAX_CYC)) begin
        // Saturate just past the limit so an overlong hold stays invalid.
        rb_cnt_q <= rb_cnt_q + RW'(1);
      end
    end
  end

  wire any_lock = gen_lock | mut_lock;

  // After a lockout clears, manual mode still owes a reset routine.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      need_reset_q <= 1'b0;
    end else if (any_lock) begin
      need_reset_q <= i_manual_reset_mode;
    end else if (rst_ok_q) begin
      need_reset_q <= 1'b0;
    end
  end

  // Mute pairs: sourcing active high, sinking pulls low when active.
  wire p1_a = i_mute_pair_one.sourcing;
  wire p1_b = ~i_mute_pair_one.sinking;
  wire p2_a = i_mute_pair_two.sourcing & i_pair_two_enable;
  wire p2_b = ~i_mute_pair_two.sinking & i_pair_two_enable;

  // A pair is valid only if both sides came on within the window; the
  // flag drops when either side drops, so a slow pair never mutes.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !(p1_a | p1_b)) begin
      m1_cnt_q <= '0;
      m1_ok_q <= 1'b0;
    end else if (p1_a & p1_b) begin
      m1_ok_q <= m1_ok_q | (m1_cnt_q <= MW'(WINDOW_CYC));
    end else if (m1_cnt_q <= MW'(WINDOW_CYC)) begin
      m1_cnt_q <= m1_cnt_q + MW'(1);
      m1_ok_q <= 1'b0;
    end else begin
      m1_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !(p2_a | p2_b)) begin
      m2_cnt_q <= '0;
      m2_ok_q <= 1'b0;
    end else if (p2_a & p2_b) begin
      m2_ok_q <= m2_ok_q | (m2_cnt_q <= MW'(WINDOW_CYC));
    end else if (m2_cnt_q <= MW'(WINDOW_CYC)) begin
      m2_cnt_q <= m2_cnt_q + MW'(1);
      m2_ok_q <= 1'b0;
    end else begin
      m2_ok_q <= 1'b0;
    end
  end

  // The mute sensors are trusted to mean hazard absent; the hazard input
  // is a second guard so a misplaced sensor cannot mute a live stroke.
  wire mute_req = (m1_ok_q | m2_ok_q) & !i_hazard_phase;
  wire lamp_mon = i_lamp_monitor_select == LAMP_MONITORED;
  wire lamp_bad = lamp_mon & !i_lamp_ok;

  // Enter mute only with a good lamp when monitored; an active mute may continue.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || any_lock || !mute_req) begin
      muted_q <= 1'b0;
    end else if (!muted_q && !lamp_bad && run_q) begin
      muted_q <= 1'b1;
    end
  end

  // Lamp fault is only reported when monitoring is selected.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lamp_fault_q <= 1'b0;
    end else begin
      lamp_fault_q <= lamp_bad;
    end
  end

  // The general stop always counts; the muteable one may be bypassed.
  wire stop_ok = gen_closed & (mut_closed | muted_q);

  // Run is held off in lockout and until any owed reset is given.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || any_lock) begin
      run_q <= 1'b0;
    end else begin
      run_q <= stop_ok && !need_reset_q;
    end
  end

  assign o_general_handshake = '{chan_a: hs_a, chan_b: hs_b};
  assign o_mutable_handshake = '{chan_a: hs_a, chan_b: hs_b};
  assign o_safety_out = run_q;
  assign o_green = run_q;
  assign o_aux_out = run_q;
  assign o_mute_indicator_out = muted_q;
  assign o_muted = muted_q;
  // Lockout stands until the in-step cycle and any owed reset are done.
  assign o_lockout = any_lock | need_reset_q;
  assign o_lamp_fault = lamp_fault_q;
endmodule

//--- ssm_pkg.sv
// Package of constants and carrier types for the safety stop input monitor.
package ssm_pkg;
  // Module clock rate in hertz.
  localparam int unsigned CLK_HZ = 25_000_000;
  // Channel simultaneity window in milliseconds.
  localparam int unsigned SIMUL_MS = 3000;
  // Simultaneity window in clock cycles, rounded down as a longest time.
  localparam int unsigned SIMUL_CYC = (CLK_HZ / 1000) * SIMUL_MS;
  // Least reset hold time in milliseconds.
  localparam int unsigned RST_MIN_MS = 250;
  // Longest reset hold time in milliseconds.
  localparam int unsigned RST_MAX_MS = 2000;
  // Least reset hold in cycles, rounded down.
  localparam int unsigned RST_MIN_CYC = (CLK_HZ / 1000) * RST_MIN_MS;
  // Longest reset hold in cycles, rounded down.
  localparam int unsigned RST_MAX_CYC = (CLK_HZ / 1000) * RST_MAX_MS;
  // Handshake test phase length in cycles.
  localparam int unsigned HS_PHASE_CYC = 8;
  // Lamp monitor setting value that selects monitored operation.
  localparam logic LAMP_MONITORED = 1'h0;

  // One two-channel pair: a safety stop input or its handshake outputs.
  typedef struct packed {
    logic chan_a;
    logic chan_b;
  } ssm_pair_t;

  // One pair of mute sensor inputs: sourcing and sinking.
  typedef struct packed {
    logic sourcing;
    logic sinking;
  } ssm_mute_pair_t;
endpackage

//--- ssm_simul.sv
// Simultaneity checker and lockout latch for one two-channel stop input.
`timescale 1ns/10ps
module ssm_simul
  import ssm_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = SIMUL_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire ssm_pair_t i_chan,
  input wire logic i_fault,
  output logic o_closed,
  output logic o_lockout,
  output logic o_cycled
);
  // Refuse at elaboration a window that the counter cannot time.
  if (WINDOW_CYC < 1) begin : g_bad_window
    $error("Simultaneity window must be at least one cycle.");
  end

  localparam int CW = $clog2(WINDOW_CYC + 1);

  // Cycles spent with the channels in disagreement.
  logic [CW-1:0] cnt_q;
  // Lockout latch; set on timeout or wiring fault.
  logic lock_q;
  // Seen both channels open in step since the lockout was set.
  logic seen_open_q;
  // Agreed state of the two channels.
  logic closed_q;
  // One-cycle pulse: a full in-step open then close cycle after lockout.
  logic cycled_q;

  wire differ = i_chan.chan_a ^ i_chan.chan_b;
  wire both_closed = i_chan.chan_a & i_chan.chan_b;
  wire both_open = ~(i_chan.chan_a | i_chan.chan_b);
  wire timeout = differ && (cnt_q >= CW'(WINDOW_CYC));

  // Count from the first transition; clear when the second channel agrees.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !differ) begin
      cnt_q <= '0;
    end else if (!timeout) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // Latch lockout; clear only after an in-step open then close cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lock_q <= 1'b0;
      seen_open_q <= 1'b0;
      cycled_q <= 1'b0;
    end else begin
      cycled_q <= 1'b0;
      if (timeout || i_fault) begin
        lock_q <= 1'b1;
        seen_open_q <= 1'b0;
      end else if (lock_q && both_open) begin
        seen_open_q <= 1'b1;
      end else if (lock_q && seen_open_q && both_closed) begin
        lock_q <= 1'b0;
        seen_open_q <= 1'b0;
        cycled_q <= 1'b1;
      end
    end
  end

  // Agreed channel state closes only when both channels close; any mismatch opens it.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      closed_q <= 1'b0;
    end else if (both_closed) begin
      closed_q <= 1'b1;
    end else if (both_open || differ) begin
      // Any opening channel stops at once; safety takes the first edge.
      closed_q <= 1'b0;
    end
  end

  assign o_closed = closed_q;
  assign o_lockout = lock_q;
  assign o_cycled = cycled_q;
endmodule

//--- ssm_monitor_chk_sva.sv
// Port-level checker for the safety stop input monitor.
`timescale 1ns/10ps
module ssm_monitor_chk
  import ssm_pkg::*;
#(
  parameter int unsigned WINDOW_CYC = SIMUL_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire ssm_pair_t i_general_stop_interface,
  input wire logic i_general_contact_mode,
  input wire logic i_hazard_phase,
  input wire logic i_lamp_monitor_select,
  input wire ssm_pair_t o_general_handshake,
  input wire logic o_safety_out,
  input wire logic o_green,
  input wire logic o_aux_out,
  input wire logic o_mute_indicator_out,
  input wire logic o_muted,
  input wire logic o_lockout,
  input wire logic o_lamp_fault
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // General channels as the monitor must read them, handshake lows masked.
  logic [1:0] gen_eff;
  // High while the two general channels disagree.
  logic gen_diff;
  // Both general channels closed.
  logic gen_both;
  // Cycles of continuous disagreement.
  int unsigned diff_cnt_q;
  assign gen_eff = i_general_stop_interface |
                   ({2{i_general_contact_mode}} & ~o_general_handshake);
  assign gen_diff = ^gen_eff;
  assign gen_both = &gen_eff;
  // The count restarts on agreement, so only one unbroken mismatch counts.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !gen_diff) begin
      diff_cnt_q <= 0;
    end else begin
      diff_cnt_q <= diff_cnt_q + 1;
    end
  end
  a_aux_follows_run: assert property (o_aux_out == o_safety_out)
    else $error("aux output differs from safety output");
  a_green_follows_run: assert property (o_green == o_safety_out)
    else $error("green differs from safety output");
  a_lock_drops_run: assert property (o_lockout |=> !o_safety_out)
    else $error("safety output on during lockout");
  a_lamp_tracks_mute: assert property (o_mute_indicator_out == o_muted)
    else $error("mute indicator differs from muted state");
  a_nomon_no_fault: assert property (i_lamp_monitor_select |=> !o_lamp_fault)
    else $error("lamp fault while unmonitored");
  a_mute_entry_ok: assert property ($rose(o_muted) |->
    !$past(i_hazard_phase) && !$past(o_lamp_fault))
    else $error("mute entered while refused");
  a_mismatch_locks: assert property
    (diff_cnt_q >= WINDOW_CYC + 3 |-> o_lockout)
    else $error("no lockout after long mismatch");
  a_hs_never_low: assert property (o_general_handshake != 2'h0)
    else $error("both handshakes low together");
  a_run_needs_gen: assert property
    (!gen_both [*3] |-> !o_safety_out)
    else $error("safety output on with general stop open");
  c_mute: cover property ($rose(o_muted));
  c_lock: cover property ($rose(o_lockout));
  c_unlock: cover property ($fell(o_lockout));
  c_lamp: cover property ($rose(o_lamp_fault));
endmodule
bind ssm_monitor ssm_monitor_chk #(.WINDOW_CYC(WINDOW_CYC)) u_chk (
  .i_ref_clk, .i_rst, .i_general_stop_interface, .i_general_contact_mode,
  .i_hazard_phase,
  .i_lamp_monitor_select, .o_general_handshake, .o_safety_out, .o_green,
  .o_aux_out, .o_mute_indicator_out, .o_muted, .o_lockout, .o_lamp_fault);

//--- ssm_far_side.sv
// Behavioural stop devices and mute sensors facing the monitor.
`timescale 1ns/10ps
module ssm_far_side
  import ssm_pkg::*;
(
  input wire logic [1:0] i_gen_close,
  input wire logic [1:0] i_mut_close,
  input wire ssm_pair_t i_gen_hs,
  input wire ssm_pair_t i_mut_hs,
  input wire logic i_contact,
  input wire logic i_short_a,
  input wire logic [1:0] i_mute_act,
  input wire logic [1:0] i_mute2_act,
  output ssm_pair_t o_gen,
  output ssm_pair_t o_mut,
  output ssm_mute_pair_t o_pair_one,
  output ssm_mute_pair_t o_pair_two
);
  // Closed hard contacts return the handshake; open ones read low.
  // A short to a foreign supply holds general channel A high regardless.
  assign o_gen = '{
    chan_a: i_short_a | (i_gen_close[1] & (i_gen_hs.chan_a | ~i_contact)),
    chan_b: i_gen_close[0] & (i_gen_hs.chan_b | ~i_contact)};
  assign o_mut = '{
    chan_a: i_mut_close[1] & (i_mut_hs.chan_a | ~i_contact),
    chan_b: i_mut_close[0] & (i_mut_hs.chan_b | ~i_contact)};
  // Sourcing is active high, sinking active low; the bench times them.
  assign o_pair_one = {i_mute_act[1], ~i_mute_act[0]};
  // Second pair has the same polarity; idle means sinking pulled high.
  assign o_pair_two = {i_mute2_act[1], ~i_mute2_act[0]};
endmodule

//--- ssm_monitor_tb.sv
// Self-checking bench for the safety stop input monitor.
`timescale 1ns/10ps
module ssm_monitor_tb;
  import ssm_pkg::*;
  // Short windows keep the run brief; expectations use these values.
  localparam int unsigned WIN = 20;
  logic i_ref_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [1:0] gen_close = 2'h3, mut_close = 2'h3, mute_act = 2'h0;
  logic contact = 1'h0, short_a = 1'h0, lamp_sel = 1'h0;
  logic lamp_ok = 1'h1, btn = 1'h0, hazard = 1'h0;
  logic p2_en = 1'h0, man = 1'h1;
  logic [1:0] mute2_act = 2'h0;
  ssm_pair_t gen, mut, gen_hs, mut_hs;
  ssm_mute_pair_t p1, p2;
  logic run, green, aux, mind, muted, lock, lfault;
  logic [3:0] st;
  logic [7:0] lfsr_q = 8'h2b;
  int failures = 0, total_checks = 0;
  // Model state, kept as integers.
  int m_lock = 0, m_run = 0, m_mute = 0, m_fault = 0, skew;
  assign st = {lock, run, muted, lfault};
  always #20 i_ref_clk = ~i_ref_clk;
  ssm_monitor #(.WINDOW_CYC(WIN), .RESET_MIN_CYC(5), .RESET_MAX_CYC(10))
  u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_mutable_stop_interface(mut), .i_general_stop_interface(gen),
    .i_general_contact_mode(contact), .i_mutable_contact_mode(contact),
    .i_mute_pair_one(p1), .i_mute_pair_two(p2), .i_pair_two_enable(p2_en),
    .i_lamp_monitor_select(lamp_sel), .i_lamp_ok(lamp_ok),
    .i_manual_reset_mode(man), .i_reset_button(btn),
    .i_hazard_phase(hazard), .o_general_handshake(gen_hs),
    .o_mutable_handshake(mut_hs), .o_safety_out(run), .o_green(green),
    .o_aux_out(aux), .o_mute_indicator_out(mind), .o_muted(muted),
    .o_lockout(lock), .o_lamp_fault(lfault));
  ssm_far_side u_far (.i_gen_close(gen_close), .i_mut_close(mut_close),
    .i_gen_hs(gen_hs), .i_mut_hs(mut_hs), .i_contact(contact),
    .i_short_a(short_a), .i_mute_act(mute_act), .i_mute2_act(mute2_act),
    .o_gen(gen), .o_mut(mut),
    .o_pair_one(p1), .o_pair_two(p2));
  // Next pseudo-random value; the seed is 43.
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Expected status word from the model.
  function automatic logic [3:0] model();
    return {m_lock[0], m_run[0], m_mute[0], m_fault[0]};
  endfunction
  // Compare and count.
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Let edges pass; sample after their updates land.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  // Wait, bounded, for the model state; a lapse ends the run.
  task automatic settle(input int bound);
    int i;
    i = 0;
    while (st !== model() && i < bound) begin
      cyc(1);
      i++;
    end
    if (st !== model()) begin
      failures++;
      results();
    end
    chk(st, model());
  endtask
  // Hold the reset button for n cycles, then release.
  task automatic press(input int n);
    @(posedge i_ref_clk);
    btn <= 1'h1;
    repeat (n) @(posedge i_ref_clk);
    btn <= 1'h0;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    i_rst <= 1'h0;
    cyc(1);
    chk({gen_hs, mut_hs}, 4'hf);
    m_run = 1;
    settle(8);
    // A failed lamp blocks mute while monitored.
    @(posedge i_ref_clk);
    lamp_ok <= 1'h0;
    mute_act <= 2'h3;
    m_fault = 1;
    settle(5);
    cyc(WIN);
    chk(st, model());
    @(posedge i_ref_clk);
    lamp_ok <= 1'h1;
    hazard <= 1'h1;
    m_fault = 0;
    settle(5);
    cyc(WIN);
    chk(st, model());
    @(posedge i_ref_clk);
    hazard <= 1'h0;
    m_mute = 1;
    settle(WIN);
    // The muteable input may open while muted without a stop.
    @(posedge i_ref_clk);
    mut_close <= 2'h0;
    cyc(5);
    chk(st, model());
    @(posedge i_ref_clk);
    mut_close <= 2'h3;
    mute_act <= 2'h0;
    m_mute = 0;
    settle(10);
    // The second pair alone mutes once it is enabled.
    @(posedge i_ref_clk);
    p2_en <= 1'h1;
    mute2_act <= 2'h3;
    m_mute = 1;
    settle(8);
    @(posedge i_ref_clk);
    mute2_act <= 2'h0;
    m_mute = 0;
    settle(8);
    // Sensors too far apart never start a mute.
    @(posedge i_ref_clk);
    mute_act <= 2'h2;
    cyc(WIN + 5);
    mute_act <= 2'h3;
    cyc(8);
    chk(st, model());
    @(posedge i_ref_clk);
    mute_act <= 2'h0;
    lamp_sel <= 1'h1;
    lamp_ok <= 1'h0;
    cyc(4);
    chk(st, model());
    @(posedge i_ref_clk);
    lamp_sel <= 1'h0;
    lamp_ok <= 1'h1;
    // Random in-step skews stay inside the window.
    for (int k = 0; k < 4; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      skew = 1 + int'(lfsr_q) % (WIN - 4);
      @(posedge i_ref_clk);
      gen_close <= 2'h1;
      cyc(skew);
      gen_close <= 2'h0;
      m_run = 0;
      settle(5);
      @(posedge i_ref_clk);
      gen_close <= 2'h2;
      cyc(skew);
      gen_close <= 2'h3;
      m_run = 1;
      settle(8);
    end
    // Long mismatch locks out, not before the window ends.
    @(posedge i_ref_clk);
    gen_close <= 2'h1;
    m_run = 0;
    cyc(WIN - 2);
    chk(st, model());
    m_lock = 1;
    settle(8);
    @(posedge i_ref_clk);
    gen_close <= 2'h0;
    cyc(3);
    gen_close <= 2'h3;
    cyc(5);
    chk(st, model());
    for (int k = 0; k < 2; k++) begin
      press(k ? 14 : 2);
      cyc(3);
      chk(st, model());
    end
    press(7);
    m_lock = 0;
    m_run = 1;
    settle(10);
    // Contact wiring with handshake, then a short on channel A.
    @(posedge i_ref_clk);
    contact <= 1'h1;
    cyc(40);
    chk(st, model());
    @(posedge i_ref_clk);
    short_a <= 1'h1;
    m_lock = 1;
    m_run = 0;
    settle(40);
    @(posedge i_ref_clk);
    i_rst <= 1'h1;
    short_a <= 1'h0;
    contact <= 1'h0;
    cyc(3);
    i_rst <= 1'h0;
    m_lock = 0;
    m_run = 1;
    settle(10);
    // Automatic reset: the in-step cycle alone clears the lockout.
    @(posedge i_ref_clk);
    man <= 1'h0;
    gen_close <= 2'h2;
    m_lock = 1;
    m_run = 0;
    settle(WIN + 8);
    @(posedge i_ref_clk);
    gen_close <= 2'h0;
    cyc(3);
    gen_close <= 2'h3;
    m_lock = 0;
    m_run = 1;
    settle(8);
    results();
  end
endmodule
